/* File: hdl/exa_pkg.sv */
// Purpose: Shared constants for the expander reset and change-alert block
// Assumes: Two ports of eight pins each unless the top is told otherwise
// Notes:   Reset values are per pin; the top replicates them
`default_nettype none
package exa_pkg;

  localparam int EXA_PORT_W = 8;
  localparam int EXA_N_PORTS = 2;
  localparam int EXA_SYNC_STAGES = 3;

  // Per-pin reset values of the configuration held in this block
  localparam logic EXA_DIR_RST = 1'h1;
  localparam logic EXA_MASK_RST = 1'h1;
  localparam logic EXA_HOLD_RST = 1'h0;

  // Field selector for the configuration write port
  typedef enum logic [1:0] {
    EXA_SEL_DIR = 2'b00,
    EXA_SEL_MASK = 2'b01,
    EXA_SEL_HOLD = 2'b10,
    EXA_SEL_NONE = 2'b11
  } exa_sel_t;

endpackage

`default_nettype wire

/* File: hdl/exa_sync.sv */
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: d comes from another clock domain or a pin
// Notes:   Output moves only when the second and third flops agree
`timescale 1ns/1ps
`default_nettype none

module exa_sync
  import exa_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } exa_sync_st_t;

  exa_sync_st_t st_r;
  exa_sync_st_t st_nxt;

  generate
    if (W < 1)
    begin : g_chk
      $error("exa_sync: W must be at least 1");
    end
  endgenerate

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Stage one is seen only by stage two, never by the filter
    st_nxt.filt = (~(st_r.s2 ^ st_r.s3) & st_r.s2) |
                  ((st_r.s2 ^ st_r.s3) & st_r.filt);
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.filt;

endmodule

`default_nettype wire

/* File: hdl/exa_alert.sv */
// Purpose: Device reset input and change-alert logic of a GPIO expander
// Assumes: Serial front end reports ACK/NACK of port reads on scl
// Notes:
// Notes on behaviour
// (RL1) Host holds the reset pin low for at least the minimum pulse width.
// (RL2) While the reset pin is low every register returns to default.
// (RL3) Register access counts only while the reset pin is high.
// (RL4) Alert is active low open-drain: pull low or release.
// (RL5) Any rising or falling edge on an input pin raises an alert.
// (RL6) Unlatched alert clears when pin returns or its port is read.
// (RL7) Output-direction pins never raise an alert.
// (RL8) Output to input switch with a mismatching level may alert.
// (RL9) Latched pin holds its alert until its port is read.
// (RL10) Read clearing happens at the ACK/NACK bit on rising scl.
// (RL11) Mask one hides a pin; unmasking pending change alerts again.
// (RL12) Source bits show pending unmasked pins, zero when masked.
// (RL13) Mask bits are all one after power-on and reset.
// (RL14) Port value is live for unlatched pins, held for latched ones.
// (RL15) Inputs are synchronised, compared with the last read value.
`timescale 1ns/1ps
`default_nettype none

module exa_alert
  import exa_pkg::*;
#(
  parameter int PORT_W = EXA_PORT_W,
  parameter int N_PORTS = EXA_N_PORTS
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic dev_reset_b,
  input wire logic [PORT_W*N_PORTS-1:0] pin_in,
  input wire logic link_ack_bit,
  input wire logic [$clog2(N_PORTS)-1:0] link_port_sel,
  input wire logic cfg_we,
  input wire exa_sel_t cfg_sel,
  input wire logic [PORT_W*N_PORTS-1:0] cfg_wdata,
  output logic alert_o,
  output logic alert_oe,
  output logic [PORT_W*N_PORTS-1:0] port_value,
  output logic [PORT_W*N_PORTS-1:0] alert_src,
  output logic dev_in_reset
);

  localparam int PINS = PORT_W * N_PORTS;

  generate
    if (N_PORTS < 2 || PORT_W < 1)
    begin : g_chk
      $error("exa_alert: need two or more ports of one or more pins");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Link side: one toggle per port, flipped at each read ACK/NACK bit
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [N_PORTS-1:0] tgl;
  } exa_link_st_t;

  exa_link_st_t lnk_r;
  exa_link_st_t lnk_nxt;

  // A toggle survives scl stopping between frames; a pulse would not
  always_comb
  begin
    lnk_nxt = lnk_r;
    if (link_ack_bit)
    begin
      lnk_nxt.tgl[link_port_sel] = ~lnk_r.tgl[link_port_sel]; // see RL10
    end
  end

  always_ff @(posedge scl or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lnk_r <= '0;
    end
    else
    begin
      lnk_r <= lnk_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the core clock
  // ----------------------------------------------------------------
  logic [PINS-1:0] pins_s;
  logic [N_PORTS-1:0] tgl_s;
  logic run_s;

  exa_sync #(.W(PINS), .RST_VAL('0)) u_pin_sync // see RL15
  (
    .clk(clk),
    .rst_b(rst_b),
    .d(pin_in),
    .q(pins_s)
  );

  exa_sync #(.W(N_PORTS), .RST_VAL('0)) u_tgl_sync
  (
    .clk(clk),
    .rst_b(rst_b),
    .d(lnk_r.tgl),
    .q(tgl_s)
  );

  exa_sync #(.W(1), .RST_VAL(1'h0)) u_rst_sync
  (
    .clk(clk),
    .rst_b(rst_b),
    .d(dev_reset_b),
    .q(run_s)
  );

  // ----------------------------------------------------------------
  // Core state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic primed;
    logic [N_PORTS-1:0] tgl_seen;
    logic [PINS-1:0] dir;
    logic [PINS-1:0] mask;
    logic [PINS-1:0] hold;
    logic [PINS-1:0] snap;
    logic [PINS-1:0] held;
    logic [PINS-1:0] latched;
    logic [PINS-1:0] src;
    logic [PINS-1:0] value;
    logic drv_lo;
    logic oe;
    logic in_rst;
  } exa_core_st_t;

  exa_core_st_t st_r;
  exa_core_st_t st_nxt;

  localparam exa_core_st_t CORE_RST = '{
    primed: 1'h0,
    tgl_seen: '0,
    dir: {PINS{EXA_DIR_RST}},
    mask: {PINS{EXA_MASK_RST}},
    hold: {PINS{EXA_HOLD_RST}},
    snap: '0,
    held: '0,
    latched: '0,
    src: '0,
    value: '0,
    drv_lo: 1'h0,
    oe: 1'h0,
    in_rst: 1'h1
  };

  always_comb
  begin
    logic [N_PORTS-1:0] rd_evt;
    logic [PINS-1:0] pend;
    logic chg;
    rd_evt = tgl_s ^ st_r.tgl_seen;
    pend = '0;
    chg = 1'h0;
    st_nxt = st_r;
    if (!run_s)
    begin
      // Reads arriving now are consumed and dropped
      st_nxt = CORE_RST; // see RL2, RL13
      st_nxt.tgl_seen = tgl_s; // see RL3
    end
    else
    begin
      st_nxt.tgl_seen = tgl_s;
      st_nxt.in_rst = 1'h0;
      if (!st_r.primed)
      begin
        // First look after reset sets the reference; no false alert
        st_nxt.snap = pins_s;
        st_nxt.primed = 1'h1;
      end
      if (cfg_we)
      begin
        if (cfg_sel == EXA_SEL_DIR)
        begin
          st_nxt.dir = cfg_wdata;
        end
        else if (cfg_sel == EXA_SEL_MASK)
        begin
          st_nxt.mask = cfg_wdata;
        end
        else if (cfg_sel == EXA_SEL_HOLD)
        begin
          st_nxt.hold = cfg_wdata;
        end
      end
      for (int i = 0; i < PINS; i++)
      begin
        chg = st_r.primed && st_r.dir[i] && (pins_s[i] != st_r.snap[i]);
        if (rd_evt[i / PORT_W])
        begin
          // Reference becomes what the host was shown
          st_nxt.snap[i] = st_r.value[i]; // see RL6, RL9, RL10
          st_nxt.latched[i] = 1'h0;
        end
        else if (chg && st_r.hold[i] && !st_r.latched[i])
        begin
          st_nxt.latched[i] = 1'h1; // see RL9
          st_nxt.held[i] = pins_s[i];
        end
      end
    end
    // Mismatch after a read is seen in the same cycle, so no edge is lost
    pend = st_nxt.dir &
           (st_nxt.latched | (pins_s ^ st_nxt.snap)); // see RL5, RL6, RL7, RL8
    if (!st_nxt.primed)
    begin
      pend = '0;
    end
    st_nxt.src = pend & ~st_nxt.mask; // see RL11, RL12
    st_nxt.oe = |st_nxt.src; // see RL4, RL11
    st_nxt.drv_lo = 1'h0;
    st_nxt.value = (st_nxt.hold & st_nxt.latched & st_nxt.held) |
                   (~(st_nxt.hold & st_nxt.latched) & pins_s); // see RL14
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= CORE_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign alert_o = st_r.drv_lo;
  assign alert_oe = st_r.oe;
  assign port_value = st_r.value;
  assign alert_src = st_r.src;
  assign dev_in_reset = st_r.in_rst;

endmodule

`default_nettype wire

/* File: tb/exa_alert_properties.sv */
// Purpose: Port-level checker for exa_alert
// Assumes: Single core clock domain on the checked ports
// Notes: Bound to every exa_alert instance
`timescale 1ns/1ps
`default_nettype none
module exa_alert_properties
  import exa_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic dev_reset_b,
  input wire logic cfg_we,
  input wire exa_sel_t cfg_sel,
  input wire logic [W-1:0] cfg_wdata,
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic [W-1:0] alert_src,
  input wire logic dev_in_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Writes only count once the reset pin has been seen high
  wire wm = cfg_we && !dev_in_reset && cfg_sel == EXA_SEL_MASK;
  wire wd = cfg_we && !dev_in_reset && cfg_sel == EXA_SEL_DIR;
  // Set while at defaults, cleared by any write, one made while at defaults included
  logic fresh_r;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fresh_r <= 1'h1;
    end
    else if (cfg_we)
    begin
      fresh_r <= 1'h0;
    end
    else if (dev_in_reset)
    begin
      fresh_r <= 1'h1;
    end
  end

  a_pin_drive: assert property (alert_o == 1'h0)
    else $error("alert pin drive value not low");
  a_oe_src: assert property (alert_oe == (|alert_src))
    else $error("alert enable disagrees with source bits");
  a_reset_quiet: assert property (
    dev_in_reset |-> !alert_oe && !alert_src)
    else $error("alert active while held at defaults");
  a_reset_follow: assert property (
    !dev_reset_b [*7] |-> dev_in_reset)
    else $error("reset pin low but block not at defaults");
  a_mask_hides: assert property (
    wm |=> !(alert_src & $past(cfg_wdata)))
    else $error("masked pin shows in source bits");
  a_dir_blocks: assert property (
    wd |=> !(alert_src & ~$past(cfg_wdata)))
    else $error("output pin shows in source bits");
  a_access_gate: assert property (
    $fell(dev_in_reset) |-> $past(dev_reset_b, 2))
    else $error("left defaults while reset pin low");
  a_masked_start: assert property (
    fresh_r && !dev_in_reset |-> !alert_oe && !alert_src)
    else $error("alert before any mask write");
endmodule

bind exa_alert exa_alert_properties #(.W(PORT_W*N_PORTS)) u_chk (
  .clk, .rst_b, .dev_reset_b, .cfg_we, .cfg_sel, .cfg_wdata, .alert_o,
  .alert_oe, .alert_src, .dev_in_reset);
`default_nettype wire

/* File: tb/exa_host.sv */
// Purpose: Host model issuing port reads on the link
// Assumes: Link clock of 6 ns, standing low between frames
// Notes: Only the ACK/NACK bit of a read reaches the block
`timescale 1ns/1ps
`default_nettype none
module exa_host
(
  output logic scl = 1'h0,
  output logic link_ack_bit = 1'h0,
  output logic link_port_sel = 1'h0
);
  task automatic read_port(input logic p);
    link_port_sel = p;
    link_ack_bit = 1'h1;
    #3 scl = 1'h1;
    #3 scl = 1'h0;
    link_ack_bit = 1'h0;
    // Released select shows the inverse so stale use is caught
    link_port_sel = ~p;
  endtask
endmodule
`default_nettype wire

/* File: tb/exa_alert_test.sv */
// Purpose: Self-checking bench for exa_alert
// Assumes: Pin changes land within 7 clk, read clears within 8
// Notes: Inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module exa_alert_test
  import exa_pkg::*;
;
  logic clk;
  logic rst_b = 1'h0;
  logic scl;
  logic dev_reset_b = 1'h1;
  logic link_ack_bit;
  logic link_port_sel;
  logic cfg_we = 1'h0;
  exa_sel_t cfg_sel = EXA_SEL_NONE;
  logic [15:0] cfg_wdata = 16'h0;
  logic [15:0] pin_in = 16'h0200;
  logic [15:0] port_value;
  logic [15:0] alert_src;
  logic alert_o;
  logic alert_oe;
  logic dev_in_reset;
  int mismatches;
  int cmp_count;
  exa_host u_host (.scl, .link_ack_bit, .link_port_sel);
  exa_alert DUT (.clk, .rst_b, .scl, .dev_reset_b, .pin_in, .link_ack_bit,
    .link_port_sel, .cfg_we, .cfg_sel, .cfg_wdata, .alert_o, .alert_oe,
    .port_value, .alert_src, .dev_in_reset);
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    if (got !== exp)
      mismatches++;
  endtask
  task wr(input exa_sel_t s, input logic [15:0] d);
    @(negedge clk);
    cfg_we = 1'h1;
    cfg_sel = s;
    cfg_wdata = d;
    @(negedge clk);
    cfg_we = 1'h0;
    @(negedge clk);
  endtask
  task flip(input logic [15:0] m);
    pin_in = pin_in ^ m;
    repeat (7) @(negedge clk);
  endtask
  task rd(input logic p);
    u_host.read_port(p);
    repeat (8) @(negedge clk);
  endtask
  task t_edges;
    wr(EXA_SEL_MASK, 16'h0);
    flip(16'h0208);
    chk(alert_src, 16'h0208);
    rd(1'h0);
    chk(alert_src, 16'h0200);
    wr(EXA_SEL_MASK, 16'h0200);
    chk(alert_src, 16'h0);
    wr(EXA_SEL_MASK, 16'h0);
    chk(alert_src, 16'h0200);
    wr(EXA_SEL_DIR, 16'hfdff);
    chk(alert_src, 16'h0);
    wr(EXA_SEL_DIR, 16'hffff);
    chk(alert_src, 16'h0200);
    flip(16'h0200);
    chk(alert_src, 16'h0);
    flip(16'h0100);
    chk(alert_src, 16'h0100);
    chk(16'(alert_oe), 16'h1);
    chk(16'(alert_o), 16'h0);
    wr(EXA_SEL_NONE, 16'hffff);
    chk(alert_src, 16'h0100);
    rd(1'h1);
    chk(alert_src, 16'h0);
    chk(16'(alert_oe), 16'h0);
    flip(16'h0100);
    chk(alert_src, 16'h0100);
    rd(1'h1);
    chk(alert_src, 16'h0);
  endtask
  task t_latch;
    wr(EXA_SEL_HOLD, 16'h0010);
    flip(16'h0010);
    flip(16'h0010);
    chk(alert_src, 16'h0010);
    chk(port_value, 16'h0218);
    flip(16'h0010);
    rd(1'h0);
    chk(alert_src, 16'h0);
    wr(EXA_SEL_HOLD, 16'h0);
  endtask
  task t_devreset;
    flip(16'h0001);
    dev_reset_b = 1'h0;
    repeat (8) @(negedge clk);
    chk(16'(dev_in_reset), 16'h1);
    wr(EXA_SEL_MASK, 16'h0);
    dev_reset_b = 1'h1;
    repeat (10) @(negedge clk);
    flip(16'h0001);
    chk(alert_src, 16'h0);
    chk(port_value, 16'h0218);
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    mismatches++;
    give_verdict;
  end
  initial
  begin
    repeat (16) @(negedge clk);
    rst_b = 1'h1;
    repeat (10) @(negedge clk);
    t_edges;
    t_latch;
    t_devreset;
    give_verdict;
  end
endmodule
`default_nettype wire
